//--- period_match_timer8_map.vh
// register offsets, field positions, reset values and timing constants of the three-timer block
`ifndef PERIOD_MATCH_TIMER8_MAP_VH
`define PERIOD_MATCH_TIMER8_MAP_VH

// address: [4:2] register within a timer, [1:0] timer instance
`define ADDR_W 5
`define OFS_COUNT_VALUE 3'h0
`define OFS_PERIOD_VALUE 3'h1
`define OFS_TIMER_CONTROL 3'h2
`define OFS_IRQ_STATUS 3'h3
`define OFS_MODULE_DISABLE 3'h4
`define OFS_CCP_TIMEBASE 3'h5
`define OFS_SERIAL_MODE 3'h6

`define NUM_TIMERS 3
`define NUM_CCP 5

// timer_control fields
`define CTL_PRESCALE_LSB 0
`define CTL_PRESCALE_MSB 1
`define CTL_RUN_BIT 2
`define CTL_POSTSCALE_LSB 3
`define CTL_POSTSCALE_MSB 6
`define CTL_WRITE_MASK 8'h7f

// irq status register fields: flag, enable, priority
`define IRQ_FLAG_BIT 0
`define IRQ_ENABLE_BIT 1
`define IRQ_PRIORITY_BIT 2

// reset values
`define RST_COUNT 8'h00
`define RST_PERIOD 8'hff
`define RST_CONTROL 8'h00

// prescale terminal counts and shift-clock mode code
`define PRE_DIV1_LAST 4'h0
`define PRE_DIV4_LAST 4'h3
`define PRE_DIV16_LAST 4'hf
`define SERIAL_MODE_TIMER_CLK 4'h3

`endif

//--- period_match_timer8.v
// three 8-bit period-match timers with prescaler, postscaler and register port
//
// Summary of operation
// - three identical independent 8-bit timers, each with own registers.
// - timers clock from the instruction clock, fosc/4, after the prescaler.
// - count increments from zero on each prescaled tick while running.
// - prescale 00 divides by 1, 01 by 4, 1x by 16.
// - count compared with period on each prescaled tick; equality gives match pulse.
// - match clears count next cycle and steps postscaler once.
// - count and period registers readable at any time, writable while module disable is clear.
// - reset clears count and sets period to all ones.
// - count write, control write or reset clears prescaler and postscaler.
// - control write leaves the count unchanged.
// - postscaler terminal sets a latched flag held until software clears.
// - postscale field n gives one flag per n+1 matches.
// - interrupt request needs enable; priority bit picks high or low.
// - unscaled match offered to ccp modules via 2-bit select each.
// - first timer match serves as spi shift clock in mode 0011.
// - in sleep the timers do not count; registers keep their values but still accept writes.
// - module-disable bit holds the timer in reset, clock disconnected.
// - control bit 2 runs the timer when set, stops it when clear.
// - control bits 6-3 postscale, 1-0 prescale, bit 7 reads zero.
`timescale 1ns/100ps
`include "period_match_timer8_map.vh"

module period_match_timer8 (
    input wire clock,
    input wire rstn,
    input wire sleep_mode,
    input wire [`ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    output reg [2:0] match_pulse,
    output reg irq_high,
    output reg irq_low,
    output reg [4:0] ccp_timebase_tick,
    output reg [1:0] spi_shift_tick
);

    // sleep comes from the power controller, off this block's logic
    reg sleep_meta_reg;
    reg sleep_sync_reg;

    // instruction clock enable: one pulse per four system clocks
    reg [1:0] inst_div_reg;
    reg inst_tick_reg;

    reg [7:0] count_value_reg [0:2];
    reg [7:0] period_value_reg [0:2];
    reg [6:0] timer_control_reg [0:2];
    reg [3:0] prescale_cnt_reg [0:2];
    reg [3:0] postscale_cnt_reg [0:2];
    reg [2:0] match_irq_flag_reg;
    reg [2:0] match_irq_enable_reg;
    reg [2:0] match_irq_priority_reg;
    reg [2:0] timer_module_disable_reg;
    reg [9:0] ccp_timebase_select_reg;
    reg [7:0] serial_port_mode_reg;

    reg [2:0] match_now;
    reg [2:0] tick_now;
    reg [2:0] flag_set;
    integer i;

    function [3:0] prescale_last;
        input [1:0] sel;
        begin
            if (sel[1]) begin
                prescale_last = `PRE_DIV16_LAST;
            end else if (sel[0]) begin
                prescale_last = `PRE_DIV4_LAST;
            end else begin
                prescale_last = `PRE_DIV1_LAST;
            end
        end
    endfunction

    function sel_write;
        input [2:0] ofs;
        input [1:0] idx;
        input integer t;
        begin
            sel_write = reg_write && (reg_addr[4:2] == ofs) && (reg_addr[1:0] == t[1:0]);
        end
    endfunction

    always @(posedge clock) begin
        if (!rstn) begin
            sleep_meta_reg <= 1'b0;
            sleep_sync_reg <= 1'b0;
            inst_div_reg <= 2'h0;
            inst_tick_reg <= 1'b0;
        end else begin
            sleep_meta_reg <= sleep_mode;
            sleep_sync_reg <= sleep_meta_reg;
            inst_div_reg <= inst_div_reg + 2'h1;
            inst_tick_reg <= (inst_div_reg == 2'h3);
        end
    end

    // a tick is a prescaled instruction-clock edge; a match is only seen on a tick,
    // so one period spans exactly period+1 prescaled edges
    always @* begin
        for (i = 0; i < `NUM_TIMERS; i = i + 1) begin
            tick_now[i] = inst_tick_reg && !sleep_sync_reg
                && timer_control_reg[i][`CTL_RUN_BIT]
                && !timer_module_disable_reg[i]
                && (prescale_cnt_reg[i] ==
                    prescale_last(timer_control_reg[i][`CTL_PRESCALE_MSB:`CTL_PRESCALE_LSB]));
            match_now[i] = tick_now[i]
                && (count_value_reg[i] == period_value_reg[i]);
            flag_set[i] = match_now[i] && (postscale_cnt_reg[i] ==
                timer_control_reg[i][`CTL_POSTSCALE_MSB:`CTL_POSTSCALE_LSB]);
        end
    end

    // each process keeps its own loop index so no variable has two drivers
    always @(posedge clock) begin : timer_regs
        integer i;
        for (i = 0; i < `NUM_TIMERS; i = i + 1) begin
            if (!rstn || timer_module_disable_reg[i]) begin
                count_value_reg[i] <= `RST_COUNT;
                period_value_reg[i] <= `RST_PERIOD;
                timer_control_reg[i] <= 7'h00;
                prescale_cnt_reg[i] <= 4'h0;
                postscale_cnt_reg[i] <= 4'h0;
                match_irq_flag_reg[i] <= 1'b0;
            end else begin
                // prescaler: counts instruction ticks, cleared by count/control writes
                if (sel_write(`OFS_COUNT_VALUE, 2'h0, i)
                        || sel_write(`OFS_TIMER_CONTROL, 2'h0, i)) begin
                    prescale_cnt_reg[i] <= 4'h0;
                    postscale_cnt_reg[i] <= 4'h0;
                end else begin
                    if (tick_now[i]) begin
                        prescale_cnt_reg[i] <= 4'h0;
                    end else if (inst_tick_reg && !sleep_sync_reg
                            && timer_control_reg[i][`CTL_RUN_BIT]) begin
                        prescale_cnt_reg[i] <= prescale_cnt_reg[i] + 4'h1;
                    end
                    if (flag_set[i]) begin
                        postscale_cnt_reg[i] <= 4'h0;
                    end else if (match_now[i]) begin
                        postscale_cnt_reg[i] <= postscale_cnt_reg[i] + 4'h1;
                    end
                end
                // count: software write wins over the running increment
                if (sel_write(`OFS_COUNT_VALUE, 2'h0, i)) begin
                    count_value_reg[i] <= reg_wdata;
                end else if (match_now[i]) begin
                    count_value_reg[i] <= 8'h00;
                end else if (tick_now[i]) begin
                    count_value_reg[i] <= count_value_reg[i] + 8'h01;
                end
                if (sel_write(`OFS_PERIOD_VALUE, 2'h0, i)) begin
                    period_value_reg[i] <= reg_wdata;
                end
                if (sel_write(`OFS_TIMER_CONTROL, 2'h0, i)) begin
                    timer_control_reg[i] <= reg_wdata[6:0];
                end
                // a new event beats a software clear in the same cycle
                if (flag_set[i]) begin
                    match_irq_flag_reg[i] <= 1'b1;
                end else if (sel_write(`OFS_IRQ_STATUS, 2'h0, i)) begin
                    match_irq_flag_reg[i] <= reg_wdata[`IRQ_FLAG_BIT];
                end
            end
        end
    end

    // enable, priority, module disable, ccp and serial selects live outside the timer reset
    always @(posedge clock) begin : config_regs
        integer i;
        if (!rstn) begin
            match_irq_enable_reg <= 3'h0;
            match_irq_priority_reg <= 3'h0;
            timer_module_disable_reg <= 3'h0;
            ccp_timebase_select_reg <= 10'h000;
            serial_port_mode_reg <= 8'h00;
        end else if (reg_write) begin
            for (i = 0; i < `NUM_TIMERS; i = i + 1) begin
                if (sel_write(`OFS_IRQ_STATUS, 2'h0, i)) begin
                    match_irq_enable_reg[i] <= reg_wdata[`IRQ_ENABLE_BIT];
                    match_irq_priority_reg[i] <= reg_wdata[`IRQ_PRIORITY_BIT];
                end
            end
            case (reg_addr[4:2])
                `OFS_MODULE_DISABLE: begin
                    timer_module_disable_reg <= reg_wdata[2:0];
                end
                `OFS_CCP_TIMEBASE: begin
                    case (reg_addr[1:0])
                        2'h0: ccp_timebase_select_reg[7:0] <= reg_wdata;
                        2'h1: ccp_timebase_select_reg[9:8] <= reg_wdata[1:0];
                        default: ccp_timebase_select_reg <= ccp_timebase_select_reg;
                    endcase
                end
                `OFS_SERIAL_MODE: begin
                    serial_port_mode_reg <= reg_wdata;
                end
                default: begin
                    serial_port_mode_reg <= serial_port_mode_reg;
                end
            endcase
        end
    end

    // outputs, all registered: match, ccp and shift ticks one cycle after the internal match, interrupts one cycle after the flag
    always @(posedge clock) begin : output_regs
        integer i;
        if (!rstn) begin
            match_pulse <= 3'h0;
            irq_high <= 1'b0;
            irq_low <= 1'b0;
            ccp_timebase_tick <= 5'h00;
            spi_shift_tick <= 2'h0;
        end else begin
            match_pulse <= match_now;
            irq_high <= |(match_irq_flag_reg & match_irq_enable_reg
                & match_irq_priority_reg);
            irq_low <= |(match_irq_flag_reg & match_irq_enable_reg
                & ~match_irq_priority_reg);
            for (i = 0; i < `NUM_CCP; i = i + 1) begin
                // select 3 has no timer behind it and yields no tick
                case (ccp_timebase_select_reg[2*i +: 2])
                    2'h0: ccp_timebase_tick[i] <= match_now[0];
                    2'h1: ccp_timebase_tick[i] <= match_now[1];
                    2'h2: ccp_timebase_tick[i] <= match_now[2];
                    default: ccp_timebase_tick[i] <= 1'b0;
                endcase
            end
            spi_shift_tick[0] <= match_now[0]
                && (serial_port_mode_reg[3:0] == `SERIAL_MODE_TIMER_CLK);
            spi_shift_tick[1] <= match_now[0]
                && (serial_port_mode_reg[7:4] == `SERIAL_MODE_TIMER_CLK);
        end
    end

    // read data valid the cycle after the read strobe only
    always @(posedge clock) begin
        if (!rstn || !reg_read) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr[4:2])
                `OFS_COUNT_VALUE: reg_rdata <= (reg_addr[1:0] == 2'h3) ? 8'h00
                    : count_value_reg[reg_addr[1:0]];
                `OFS_PERIOD_VALUE: reg_rdata <= (reg_addr[1:0] == 2'h3) ? 8'h00
                    : period_value_reg[reg_addr[1:0]];
                `OFS_TIMER_CONTROL: reg_rdata <= (reg_addr[1:0] == 2'h3) ? 8'h00
                    : {1'b0, timer_control_reg[reg_addr[1:0]]};
                `OFS_IRQ_STATUS: reg_rdata <= (reg_addr[1:0] == 2'h3) ? 8'h00
                    : {5'h00, match_irq_priority_reg[reg_addr[1:0]],
                       match_irq_enable_reg[reg_addr[1:0]],
                       match_irq_flag_reg[reg_addr[1:0]]};
                `OFS_MODULE_DISABLE: reg_rdata <= {5'h00, timer_module_disable_reg};
                `OFS_CCP_TIMEBASE: reg_rdata <= (reg_addr[1:0] == 2'h0)
                    ? ccp_timebase_select_reg[7:0]
                    : (reg_addr[1:0] == 2'h1) ? {6'h00, ccp_timebase_select_reg[9:8]} : 8'h00;
                `OFS_SERIAL_MODE: reg_rdata <= serial_port_mode_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

//--- period_match_timer8_asserts.sv
// port-level checks of the three-timer block
`timescale 1ns/100ps
`include "period_match_timer8_map.vh"
module period_match_timer8_asserts (
    input wire clock,
    input wire rstn,
    input wire sleep_mode,
    input wire [`ADDR_W-1:0] reg_addr,
    input wire reg_read,
    input wire [7:0] reg_rdata,
    input wire [2:0] match_pulse,
    input wire irq_high,
    input wire irq_low,
    input wire [4:0] ccp_timebase_tick,
    input wire [1:0] spi_shift_tick
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    AST_UNMAPPED: assert property (reg_read && (reg_addr[4:2] == 3'h7 ||
        reg_addr[1:0] == 2'h3 && !reg_addr[4]) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_CTL_BIT7: assert property (reg_read && reg_addr[4:2] == 3'h2 |=> !reg_rdata[7])
        else $error("control bit 7 not zero");
    // instruction ticks come every fourth clock, so matches cannot be closer
    AST_MATCH_GAP: assert property (match_pulse[0] |=> (!match_pulse[0]) [*3])
        else $error("matches closer than one tick");
    AST_SLEEP_QUIET: assert property (sleep_mode [*8] |=> match_pulse == 3'b000)
        else $error("match during sleep");
    AST_SPI_SRC: assert property (spi_shift_tick[0] |->
        match_pulse[0] || $past(match_pulse[0]))
        else $error("shift tick without timer 0 match");
    AST_CCP_SRC: assert property (ccp_timebase_tick != 5'h00 |->
        match_pulse != 3'b000 || $past(match_pulse) != 3'b000)
        else $error("time base tick without match");
    AST_RESET_QUIET: assert property ($rose(rstn) |-> (match_pulse == 3'b000) [*8])
        else $error("match right after reset");
    AST_IRQ_RESET: assert property ($rose(rstn) |-> !irq_high && !irq_low)
        else $error("interrupt right after reset");
endmodule
bind period_match_timer8 period_match_timer8_asserts u_period_match_timer8_asserts (
    .clock(clock), .rstn(rstn), .sleep_mode(sleep_mode), .reg_addr(reg_addr),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .match_pulse(match_pulse),
    .irq_high(irq_high), .irq_low(irq_low), .ccp_timebase_tick(ccp_timebase_tick),
    .spi_shift_tick(spi_shift_tick));

//--- ccp_spi_sink.sv
// consumer side of the time-base ticks: counts each ccp and shift-clock line
`timescale 1ns/100ps
module ccp_spi_sink (
    input wire clock,
    input wire clr,
    input wire [4:0] ccp_tick,
    input wire [1:0] spi_tick,
    output reg [39:0] ccp_cnt,
    output reg [15:0] spi_cnt
);
    integer k;
    always @(posedge clock) begin
        for (k = 0; k < 5; k = k + 1) begin
            if (clr) ccp_cnt[8*k +: 8] <= 8'h00;
            else if (ccp_tick[k]) ccp_cnt[8*k +: 8] <= ccp_cnt[8*k +: 8] + 8'h01;
            if (k < 2 && clr) spi_cnt[8*k +: 8] <= 8'h00;
            else if (k < 2 && spi_tick[k]) spi_cnt[8*k +: 8] <= spi_cnt[8*k +: 8] + 8'h01;
        end
    end
endmodule

//--- period_match_timer8_bench.sv
// self-checking bench for the three-timer block
`timescale 1ns/100ps
`include "period_match_timer8_map.vh"
module period_match_timer8_bench;
    reg clock = 1'b0;
    reg rstn = 1'b0;
    reg sleep_mode = 1'b0;
    reg [`ADDR_W-1:0] reg_addr = 5'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_write = 1'b0;
    reg reg_read = 1'b0;
    reg sink_clr = 1'b0;
    wire [7:0] reg_rdata;
    wire [2:0] match_pulse;
    wire irq_high;
    wire irq_low;
    wire [4:0] ccp_timebase_tick;
    wire [1:0] spi_shift_tick;
    wire [39:0] ccp_cnt;
    wire [15:0] spi_cnt;
    integer n_mismatch = 0;
    integer tests_run = 0;
    integer cycles = 0;
    integer i;
    integer n;
    period_match_timer8 u_period_match_timer8 (.clock(clock), .rstn(rstn),
        .sleep_mode(sleep_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .match_pulse(match_pulse), .irq_high(irq_high), .irq_low(irq_low),
        .ccp_timebase_tick(ccp_timebase_tick), .spi_shift_tick(spi_shift_tick));
    ccp_spi_sink u_ccp_spi_sink (.clock(clock), .clr(sink_clr), .ccp_tick(ccp_timebase_tick),
        .spi_tick(spi_shift_tick), .ccp_cnt(ccp_cnt), .spi_cnt(spi_cnt));
    initial forever #12.5 clock = ~clock;
    task finish_test;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            finish_test;
        end
    end
    task chk(input [15:0] got, input [15:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR t=%0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [4:0] a, input [7:0] d);
        begin
            @(posedge clock);
            reg_addr <= a;
            reg_wdata <= d;
            reg_write <= 1'b1;
            @(posedge clock);
            reg_write <= 1'b0;
        end
    endtask
    task rd(input [4:0] a, input [7:0] e);
        begin
            @(posedge clock);
            reg_addr <= a;
            reg_read <= 1'b1;
            @(posedge clock);
            reg_read <= 1'b0;
            @(negedge clock);
            chk(reg_rdata, e);
        end
    endtask
    // clocks between two timer 0 matches; waits are cut by the cycle ceiling
    task gap(input [15:0] e);
        begin
            n = 1;
            @(negedge clock);
            while (match_pulse[0] !== 1'b1) @(negedge clock);
            @(negedge clock);
            while (match_pulse[0] !== 1'b1) begin
                n = n + 1;
                @(negedge clock);
            end
            chk(n[15:0], e);
        end
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        for (i = 0; i < 3; i = i + 1) begin
            rd({`OFS_COUNT_VALUE, i[1:0]}, `RST_COUNT);
            rd({`OFS_PERIOD_VALUE, i[1:0]}, `RST_PERIOD);
            rd({`OFS_TIMER_CONTROL, i[1:0]}, `RST_CONTROL);
        end
        rd(5'h03, 8'h00);
        rd(5'h1c, 8'h00);
        $display("reset values done");
        wr(5'h05, 8'h5a);
        rd(5'h05, 8'h5a);
        wr(5'h09, 8'hff);
        rd(5'h09, 8'h7f);
        wr(5'h09, 8'h00);
        wr(5'h01, 8'h33);
        wr(5'h09, 8'h78);
        repeat (40) @(posedge clock);
        rd(5'h01, 8'h33);
        $display("register access done");
        wr(5'h04, 8'h03);
        for (i = 0; i < 4; i = i + 1) begin
            wr(5'h08, {5'h01, i[1:0]});
            gap(i == 0 ? 16'd16 : i == 1 ? 16'd64 : 16'd256);
        end
        $display("prescale done");
        wr(5'h05, 8'h00);
        for (i = 0; i < 16; i = i + 1) begin
            wr(5'h09, 8'h00);
            wr(5'h0d, 8'h06);
            wr(5'h09, {i[3:0], 3'b100});
            n = 0;
            @(negedge clock);
            while (irq_high !== 1'b1 && n < 40) begin
                if (match_pulse[1] === 1'b1) n = n + 1;
                @(negedge clock);
            end
            chk(n[15:0], i[15:0] + 16'd1);
        end
        wr(5'h09, 8'h00);
        wr(5'h0d, 8'h03);
        repeat (2) @(negedge clock);
        chk({irq_high, irq_low}, 2'b01);
        wr(5'h0d, 8'h01);
        repeat (2) @(negedge clock);
        chk({irq_high, irq_low}, 2'b00);
        rd(5'h0d, 8'h01);
        $display("postscale and interrupt done");
        wr(5'h08, 8'h00);
        wr(5'h00, 8'h00);
        @(posedge clock);
        sleep_mode <= 1'b1;
        repeat (4) @(posedge clock);
        wr(5'h08, 8'h04);
        wr(5'h04, 8'h20);
        repeat (100) @(posedge clock);
        rd(5'h00, 8'h00);
        rd(5'h04, 8'h20);
        @(posedge clock);
        sleep_mode <= 1'b0;
        wr(5'h08, 8'h00);
        $display("sleep done");
        wr(5'h02, 8'h44);
        wr(5'h10, 8'h04);
        rd(5'h02, 8'h00);
        wr(5'h02, 8'h55);
        rd(5'h02, 8'h00);
        wr(5'h10, 8'h00);
        rd(5'h06, 8'hff);
        $display("module disable done");
        wr(5'h14, 8'he4);
        wr(5'h15, 8'h03);
        wr(5'h18, 8'h03);
        wr(5'h04, 8'h03);
        @(posedge clock);
        sink_clr <= 1'b1;
        @(posedge clock);
        sink_clr <= 1'b0;
        wr(5'h08, 8'h04);
        n = 0;
        while (n < 8) begin
            @(negedge clock);
            if (match_pulse[0] === 1'b1) n = n + 1;
        end
        wr(5'h08, 8'h00);
        repeat (4) @(posedge clock);
        chk(ccp_cnt[15:0], 16'h0008);
        chk(ccp_cnt[39:24], 16'h0000);
        chk(ccp_cnt[23:16], 16'h0000);
        chk(spi_cnt, 16'h0008);
        $display("time base routing done");
        finish_test;
    end
endmodule
